/* File: rtl/cbr_pkg.sv */
// shared constants, types and helpers for the configurable block ram
package cbr_pkg;
	localparam int ROW_W     = 36;      // one storage row, widest port word
	localparam int ROWS      = 512;     // 512 rows x 36 bits = 18 Kbit
	localparam int ROW_AW    = 9;
	localparam int ADDR_W    = 14;      // deepest shape is 16384 x 1
	localparam int LANE_W    = 9;       // 8 data bits plus one parity bit
	localparam int LANES     = 4;
	localparam int OFF_W     = 6;
	localparam int BITADDR_W = 20;

	typedef enum logic [1:0] {
		CBR_SINGLE = 2'b00,
		CBR_TRUE_DP = 2'b01,
		CBR_PSEUDO_DP = 2'b10
	} cbr_mode_t;

	typedef enum logic [2:0] {
		CBR_W1  = 3'b000,
		CBR_W2  = 3'b001,
		CBR_W4  = 3'b010,
		CBR_W9  = 3'b011,
		CBR_W18 = 3'b100,
		CBR_W36 = 3'b101
	} cbr_width_t;

	typedef struct packed {
		logic               ce;     // port access this cycle
		logic               we;     // write when set, read when clear
		logic [LANES-1:0]   be;     // byte lane enables, 18 and 36 bit only
		logic [ADDR_W-1:0]  addr;   // word address in the port's own width
		logic [ROW_W-1:0]   wdata;  // write data, low bits used
	} cbr_req_t;

	function automatic logic [OFF_W-1:0] cbr_bits(input cbr_width_t w);
		case (w)
			CBR_W1:  cbr_bits = 6'h01;
			CBR_W2:  cbr_bits = 6'h02;
			CBR_W4:  cbr_bits = 6'h04;
			CBR_W9:  cbr_bits = 6'h09;
			CBR_W18: cbr_bits = 6'h12;
			default: cbr_bits = 6'h24;
		endcase
	endfunction : cbr_bits

	function automatic logic [ADDR_W-1:0] cbr_depth_mask(input cbr_width_t w);
		case (w)
			CBR_W1:  cbr_depth_mask = 14'h3FFF;
			CBR_W2:  cbr_depth_mask = 14'h1FFF;
			CBR_W4:  cbr_depth_mask = 14'h0FFF;
			CBR_W9:  cbr_depth_mask = 14'h07FF;
			CBR_W18: cbr_depth_mask = 14'h03FF;
			default: cbr_depth_mask = 14'h01FF;
		endcase
	endfunction : cbr_depth_mask
endpackage : cbr_pkg

/* File: rtl/cbr_block_ram.sv */
// configurable 18 Kbit block ram: port slice and top level
`timescale 1ns/1ps

module cbr_port (
	input  wire logic                   clk,       // port clock
	input  wire logic                   rst,       // sync reset, active high
	input  wire logic                   en,        // port usable in this mode
	input  wire logic                   allow_wr,  // mode lets this port write
	input  wire logic                   allow_rd,  // mode lets this port read
	input  wire cbr_pkg::cbr_width_t    width,     // port shape
	input  wire logic                   oreg,      // output register in path
	input  wire cbr_pkg::cbr_req_t      req,       // access request
	input  wire logic [35:0]            row_rdata, // storage row at row_idx
	output logic [8:0]                  row_idx,   // storage row addressed
	output logic [35:0]                 wr_mask,   // row bits written
	output logic [35:0]                 wr_bits,   // write data aligned to row
	output logic                        wr,        // write this cycle
	output logic [35:0]                 dout_q     // read data
);
	import cbr_pkg::*;

	logic [ADDR_W-1:0]    word_addr;
	logic [BITADDR_W-1:0] bit_addr;
	logic [OFF_W-1:0]     bit_off;
	logic [ROW_W-1:0]     low_mask;
	logic [ROW_W-1:0]     lane_mask;
	logic [ROW_W-1:0]     word_mask;
	logic [ROW_W-1:0]     rd_word;
	logic                 rd;
	logic                 lanes_used;
	logic [ROW_W-1:0]     stage_q;

	// word k of width W starts at bit k*W of the array, for every width
	assign word_addr = req.addr & cbr_depth_mask(width);                      // [R3]
	assign bit_addr  = BITADDR_W'(word_addr) * BITADDR_W'(cbr_bits(width));   // [R7]
	assign row_idx   = ROW_AW'(bit_addr / BITADDR_W'(ROW_W));                 // [R7]
	assign bit_off   = OFF_W'(bit_addr % BITADDR_W'(ROW_W));                  // [R7]
	assign low_mask  = ~(36'hFFFFFFFFF << cbr_bits(width));

	// byte enables only mean something at 18 and 36 bits
	assign lanes_used = (width == CBR_W18) || (width == CBR_W36);             // [R5]
	genvar gl;
	generate
		for (gl = 0; gl < LANES; gl++) begin : g_lane
			assign lane_mask[gl*LANE_W +: LANE_W] =
				{LANE_W{req.be[gl] | ~lanes_used}};                           // [R5]
		end
	endgenerate

	// parity bits are plain storage; fabric logic makes and checks them
	assign word_mask = low_mask & lane_mask;                                  // [R4]
	assign wr        = en & allow_wr & req.ce & req.we;                       // [R10]
	assign wr_mask   = word_mask << bit_off;                                  // [R5]
	assign wr_bits   = (req.wdata & low_mask) << bit_off;                     // [R10]
	assign rd        = en & allow_rd & req.ce & ~req.we;                      // [R12]
	assign rd_word   = (row_rdata >> bit_off) & low_mask;

	// array read is captured on the same edge as address, like a sync ram
	always_ff @(posedge clk) begin
		if (rst) begin
			stage_q <= 36'h000000000;
		end else if (rd) begin
			stage_q <= rd_word;                                               // [R12]
		end
	end

	// bypass: data after the address edge; registered: one edge later
	always_ff @(posedge clk) begin
		if (rst) begin
			dout_q <= 36'h000000000;
		end else if (oreg) begin
			dout_q <= stage_q;                                                // [R11] [R14]
		end else if (rd) begin
			dout_q <= rd_word;                                                // [R14]
		end
	end                                                                       // [R13]
endmodule : cbr_port

// Summary of operation
// [R1] 18 Kbit array with input and output registers
// [R2] single port, true dual or pseudo dual port
// [R3] shapes 16384x1 to 512x36; none 512x36 true dual
// [R4] optional ninth parity bit stored per byte
// [R5] byte enables gate lanes at 18/36 bits
// [R6] each port has its own width and depth
// [R7] word k occupies bits k*W upward, all ports
// [R8] contents may be preloaded before user operation
// [R9] rom use: fabric keeps write controls inactive
// [R10] write data and address registered at port edge
// [R11] output register optional, adds one clock latency
// [R12] output changes only on reads, never writes
// [R13] during write, output holds last read data
// [R14] bypass valid after address edge, else next
module cbr_block_ram (
	input  wire logic                  clk,          // port clock
	input  wire logic                  rst,          // sync reset, active high
	input  wire cbr_pkg::cbr_mode_t    cfg_mode,     // memory mode
	input  wire cbr_pkg::cbr_width_t   cfg_width_a,  // port a shape
	input  wire cbr_pkg::cbr_width_t   cfg_width_b,  // port b shape
	input  wire logic                  cfg_oreg_a,   // port a output register
	input  wire logic                  cfg_oreg_b,   // port b output register
	input  wire logic                  init_done,    // preload over, user mode
	input  wire logic                  init_we,      // preload row write
	input  wire logic [8:0]            init_row,     // preload row index
	input  wire logic [35:0]           init_data,    // preload row contents
	input  wire cbr_pkg::cbr_req_t     req_a,        // port a request
	input  wire cbr_pkg::cbr_req_t     req_b,        // port b request
	output logic [35:0]                dout_a_q,     // port a read data
	output logic [35:0]                dout_b_q,     // port b read data
	output logic                       cfg_err_q,    // illegal shape for mode
	output logic                       wr_clash_q    // both ports wrote one bit
);
	import cbr_pkg::*;

	logic [ROW_W-1:0] mem [ROWS];                                             // [R1]

	logic             mode_single;
	logic             mode_tdp;
	logic             mode_pdp;
	logic             bad_a;
	logic             bad_b;
	logic             en_a;
	logic             en_b;
	logic             wr_a;
	logic             wr_b;
	logic [8:0]       row_a;
	logic [8:0]       row_b;
	logic [35:0]      mask_a;
	logic [35:0]      mask_b;
	logic [35:0]      bits_a;
	logic [35:0]      bits_b;
	logic             same_row;
	logic [35:0]      merged;
	logic             clash;

	assign mode_single = (cfg_mode == CBR_SINGLE);                            // [R2]
	assign mode_tdp    = (cfg_mode == CBR_TRUE_DP);                           // [R2]
	assign mode_pdp    = (cfg_mode == CBR_PSEUDO_DP);                         // [R2]

	// 36 bits needs both row halves per port, so true dual port lacks it
	assign bad_a = mode_tdp && (cfg_width_a == CBR_W36);                      // [R3]
	assign bad_b = mode_tdp && (cfg_width_b == CBR_W36);                      // [R3]
	assign en_a  = init_done & ~bad_a & (mode_single | mode_tdp | mode_pdp);  // [R8]
	assign en_b  = init_done & ~bad_b & (mode_tdp | mode_pdp);                // [R2]

	// pseudo dual: a writes only, b reads only; widths stay per port
	cbr_port u_port_a (
		.clk       (clk),
		.rst       (rst),
		.en        (en_a),
		.allow_wr  (1'b1),
		.allow_rd  (~mode_pdp),                                               // [R2]
		.width     (cfg_width_a),                                             // [R6]
		.oreg      (cfg_oreg_a),                                              // [R11]
		.req       (req_a),
		.row_rdata (mem[row_a]),
		.row_idx   (row_a),
		.wr_mask   (mask_a),
		.wr_bits   (bits_a),
		.wr        (wr_a),
		.dout_q    (dout_a_q)
	);

	cbr_port u_port_b (
		.clk       (clk),
		.rst       (rst),
		.en        (en_b),
		.allow_wr  (~mode_pdp),                                               // [R2]
		.allow_rd  (1'b1),
		.width     (cfg_width_b),                                             // [R6]
		.oreg      (cfg_oreg_b),                                              // [R11]
		.req       (req_b),
		.row_rdata (mem[row_b]),
		.row_idx   (row_b),
		.wr_mask   (mask_b),
		.wr_bits   (bits_b),
		.wr        (wr_b),
		.dout_q    (dout_b_q)
	);

	// same-row writes are merged so neither port loses its bits; b wins overlap
	assign same_row = wr_a && wr_b && (row_a == row_b);
	assign clash    = same_row && ((mask_a & mask_b) != 36'h000000000);
	assign merged   = (mem[row_a] & ~mask_a & ~mask_b) | (bits_a & mask_a & ~mask_b)
		| (bits_b & mask_b);

	// no reset on the array: contents survive rst, as preloaded data must
	always_ff @(posedge clk) begin
		if (!init_done) begin
			if (init_we) begin
				mem[init_row] <= init_data;                                   // [R8]
			end
		end else if (same_row) begin
			mem[row_a] <= merged;                                             // [R10]
		end else begin
			if (wr_a) begin
				mem[row_a] <= (mem[row_a] & ~mask_a) | (bits_a & mask_a);     // [R10]
			end
			if (wr_b) begin
				mem[row_b] <= (mem[row_b] & ~mask_b) | (bits_b & mask_b);     // [R10]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_err_q  <= 1'b0;
			wr_clash_q <= 1'b0;
		end else begin
			cfg_err_q  <= bad_a | bad_b;                                      // [R3]
			wr_clash_q <= clash;
		end
	end
endmodule : cbr_block_ram

/* File: test/cbr_fabric.sv */
// fabric-side request source facing one ram port
`timescale 1ns/1ps
module cbr_fabric (
	input  wire logic              rom, // read-only use, writes held off
	input  wire cbr_pkg::cbr_req_t cmd, // request from the bench
	output cbr_pkg::cbr_req_t      req  // request to the ram port
);
	import cbr_pkg::*;
	wire logic blocked = rom & cmd.we;
	// a blocked write is dropped whole, not turned into a read
	always_comb begin
		req = cmd;
		req.ce = cmd.ce & ~blocked;
	end
endmodule : cbr_fabric

/* File: test/cbr_chk.sv */
// port assertions for the configurable block ram
`timescale 1ns/1ps
module cbr_chk (
	input wire logic                clk,         // clock
	input wire logic                rst,         // sync reset
	input wire cbr_pkg::cbr_mode_t  cfg_mode,    // mode
	input wire cbr_pkg::cbr_width_t cfg_width_a, // port a shape
	input wire cbr_pkg::cbr_width_t cfg_width_b, // port b shape
	input wire logic                init_done,   // user phase
	input wire cbr_pkg::cbr_req_t   req_a,       // port a request
	input wire cbr_pkg::cbr_req_t   req_b,       // port b request
	input wire logic [35:0]         dout_a_q,    // port a data
	input wire logic [35:0]         dout_b_q,    // port b data
	input wire logic                cfg_err_q,   // shape error
	input wire logic                wr_clash_q   // dual write clash
);
	import cbr_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire logic rd_a = req_a.ce & ~req_a.we;
	wire logic rd_b = req_b.ce & ~req_b.we;
	wire logic bad  = (cfg_mode == CBR_TRUE_DP)
		& ((cfg_width_a == CBR_W36) | (cfg_width_b == CBR_W36));
	wire logic both = init_done & req_a.ce & req_a.we & req_b.ce & req_b.we;
	sequence s_no_rd_a; !rd_a [*2]; endsequence
	sequence s_no_rd_b; !rd_b [*2]; endsequence
	property p_rst;
		disable iff (1'b0) rst |=> dout_a_q == 36'h0 && dout_b_q == 36'h0
			&& !cfg_err_q && !wr_clash_q;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	property p_hold_a; s_no_rd_a |=> $stable(dout_a_q); endproperty
	a_hold_a: assert property (p_hold_a) else $error("port a moved without read");
	property p_hold_b; s_no_rd_b |=> $stable(dout_b_q); endproperty
	a_hold_b: assert property (p_hold_b) else $error("port b moved without read");
	property p_pre; !init_done [*2] |=> $stable(dout_a_q) && $stable(dout_b_q); endproperty
	a_pre: assert property (p_pre) else $error("port answered during preload");
	property p_one_b; (cfg_mode == CBR_SINGLE) [*2] |=> $stable(dout_b_q); endproperty
	a_one_b: assert property (p_one_b) else $error("port b active in single mode");
	property p_pdp_a; (cfg_mode == CBR_PSEUDO_DP) [*2] |=> $stable(dout_a_q); endproperty
	a_pdp_a: assert property (p_pdp_a) else $error("port a read in pseudo dual mode");
	property p_x36;
		(cfg_mode == CBR_TRUE_DP && cfg_width_a == CBR_W36) [*2] |=> $stable(dout_a_q);
	endproperty
	a_x36: assert property (p_x36) else $error("x36 port a active in true dual mode");
	property p_err; 1'b1 |=> cfg_err_q == $past(bad); endproperty
	a_err: assert property (p_err) else $error("shape error flag wrong");
	property p_clash; wr_clash_q |-> $past(both); endproperty
	a_clash: assert property (p_clash) else $error("clash flag without two writes");
endmodule : cbr_chk
bind cbr_block_ram cbr_chk u_cbr_chk (.clk, .rst, .cfg_mode, .cfg_width_a, .cfg_width_b, .init_done,
	.req_a, .req_b, .dout_a_q, .dout_b_q, .cfg_err_q, .wr_clash_q);

/* File: test/tb_top.sv */
// self-checking bench for the configurable block ram
`timescale 1ns/1ps
module tb_top;
	import cbr_pkg::*;
	logic        clk   = 1'b0;
	logic        rst   = 1'b1;
	cbr_mode_t   mode  = CBR_SINGLE;
	cbr_width_t  wa    = CBR_W36;
	cbr_width_t  wb    = CBR_W36;
	logic        ob    = 1'b0;
	logic        idone = 1'b0;
	logic        iwe   = 1'b0;
	logic        rom_a = 1'b0;
	logic [35:0] idata = 36'h0;
	cbr_req_t    cmd_a = '0;
	cbr_req_t    cmd_b = '0;
	cbr_req_t    req_a, req_b;
	logic [35:0] dout_a_q, dout_b_q;
	logic        cfg_err_q, wr_clash_q;
	int          miscompares = 0;
	int          checks = 0;
	always #2.5 clk = ~clk;
	cbr_fabric fab_a (.rom(rom_a), .cmd(cmd_a), .req(req_a));
	cbr_fabric fab_b (.rom(1'b0), .cmd(cmd_b), .req(req_b));
	cbr_block_ram u_cbr_block_ram (.clk, .rst, .cfg_mode(mode), .cfg_width_a(wa), .cfg_width_b(wb),
		.cfg_oreg_a(ob), .cfg_oreg_b(ob), .init_done(idone), .init_we(iwe), .init_row(9'h000),
		.init_data(idata), .req_a, .req_b, .dout_a_q, .dout_b_q, .cfg_err_q, .wr_clash_q);
	task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	function automatic cbr_req_t mk(input logic we, input logic [3:0] be, input logic [13:0] ad,
		input logic [35:0] wd);
		mk = '{ce: 1'b1, we: we, be: be, addr: ad, wdata: wd};
	endfunction : mk
	// one request per port, taken on the second edge, then released
	task automatic op(input cbr_req_t ra, input cbr_req_t rb);
		@(posedge clk);
		cmd_a <= ra;
		cmd_b <= rb;
		@(posedge clk);
		cmd_a <= '0;
		cmd_b <= '0;
		#1;
	endtask : op
	task automatic cfg(input cbr_mode_t m, input cbr_width_t a, input cbr_width_t b);
		@(posedge clk);
		mode <= m;
		wa <= a;
		wb <= b;
	endtask : cfg
	task automatic t_rom();
		cbr_width_t  tw [6] = '{CBR_W36, CBR_W18, CBR_W9, CBR_W4, CBR_W2, CBR_W1};
		logic [13:0] ta [6] = '{14'h0000, 14'h0001, 14'h0003, 14'h0001, 14'h0001, 14'h0000};
		logic [35:0] te [6] = '{36'h123456789, 36'h0000048D1, 36'h000000024, 36'h000000008,
			36'h000000002, 36'h000000001};
		@(posedge clk);
		iwe <= 1'b1;
		idata <= 36'h123456789;
		@(posedge clk);
		iwe <= 1'b0;
		idone <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			cfg(CBR_SINGLE, tw[i], CBR_W36);
			op(mk(1'b0, 4'h0, ta[i], 36'h0), '0);
			chk("shape read", te[i], dout_a_q);
		end
		@(posedge clk);
		rom_a <= 1'b1;
		op(mk(1'b1, 4'hF, 14'h0000, 36'h0), '0);
		@(posedge clk);
		rom_a <= 1'b0;
		op(mk(1'b0, 4'h0, 14'h0000, 36'h0), '0);
		chk("rom word", 36'h1, dout_a_q);
	endtask : t_rom
	task automatic t_bytes();
		cfg(CBR_SINGLE, CBR_W18, CBR_W36);
		op(mk(1'b1, 4'hF, 14'h0004, 36'h3FFFF), '0);
		op(mk(1'b1, 4'h1, 14'h0004, 36'h0), '0);
		op(mk(1'b0, 4'h0, 14'h0004, 36'h0), '0);
		chk("lane write", 36'h3FE00, dout_a_q);
		op(mk(1'b1, 4'h2, 14'h0004, 36'h0), '0);
		chk("hold on write", 36'h3FE00, dout_a_q);
	endtask : t_bytes
	task automatic t_dual();
		cfg(CBR_TRUE_DP, CBR_W9, CBR_W18);
		op(mk(1'b1, 4'h0, 14'h000C, 36'h0A5), '0);
		op(mk(1'b1, 4'h0, 14'h000D, 36'h15A), '0);
		op('0, mk(1'b0, 4'h0, 14'h0006, 36'h0));
		chk("cross width", 36'h2B4A5, dout_b_q);
		cfg(CBR_TRUE_DP, CBR_W36, CBR_W18);
		op(mk(1'b0, 4'h0, 14'h0000, 36'h0), '0);
		chk("x36 dual flag", 36'h1, {35'h0, cfg_err_q});
		chk("x36 dual read", 36'h3FE00, dout_a_q);
	endtask : t_dual
	task automatic t_oreg();
		cfg(CBR_PSEUDO_DP, CBR_W36, CBR_W36);
		ob <= 1'b1;
		op(mk(1'b1, 4'hF, 14'h0007, 36'hC3C3C3C3C), '0);
		op(mk(1'b0, 4'h0, 14'h0007, 36'h0), mk(1'b0, 4'h0, 14'h0007, 36'h0));
		chk("oreg first edge", 36'h2B4A5, dout_b_q);
		chk("pseudo port a read", 36'h3FE00, dout_a_q);
		@(posedge clk);
		#1;
		chk("oreg second edge", 36'hC3C3C3C3C, dout_b_q);
	endtask : t_oreg
	task automatic t_clash();
		cfg(CBR_TRUE_DP, CBR_W1, CBR_W1);
		ob <= 1'b0;
		op(mk(1'b1, 4'hF, 14'h0010, 36'h1), mk(1'b1, 4'hF, 14'h0010, 36'h0));
		chk("clash flag", 36'h1, {35'h0, wr_clash_q});
		op('0, mk(1'b0, 4'h0, 14'h0010, 36'h0));
		chk("clash winner", 36'h0, dout_b_q);
	endtask : t_clash
	task automatic finish_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_rom();
		t_bytes();
		t_dual();
		t_oreg();
		t_clash();
		finish_test();
	end
	// the whole sequence needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		finish_test();
	end
endmodule : tb_top
